// file: logic/fpdc_ctrl.sv
// Host controller driving a 72-bit fast-page DRAM module
`include "fpdc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01 - Each access moves one full 72-bit word
// R02 - Issue 2048 refreshes every 32 ms
// R03 - Module accepts CBR, row-only, hidden refresh
// R04 - Wait over 100 us, eight dummy refreshes
// R05 - Presence pins report speed grade pattern
// R06 - Detect gate enables presence pattern
// R07 - Identity pins read as ground
// R08 - Row and column on eleven plus one addresses
// R09 - 72 shared data lines, both directions
// R10 - Two active-low row strobes
// R11 - Two active-low column strobes per half; the code drives one per half (col_strobe_n_a_out, col_strobe_n_b_out)
// R12 - Two active-low write enables
// R13 - Two active-low output enables
// R14 - Row low limits 10000 ns, 125000 ns page
// R15 - Page column spacing at least 40 ns
// R16 - Early write keeps module outputs off
// R17 - Read command hold met at column strobe
// R18 - CBR refresh needs no row address
module fpdc_ctrl
    import fpdc_pkg::*;
#(
    parameter int PWRUP_CYC = `FPDC_PWRUP_CYC,
    parameter int REF_INTERVAL_CYC = `FPDC_REF_INTERVAL_CYC,
    parameter int PAGE_ROW_ACTIVE_MAX_CYC = `FPDC_PAGE_ROW_ACTIVE_MAX_CYC,
    parameter int TRASN_CYC = `FPDC_TRASN_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [`FPDC_ADDR_BITS-1:0] req_addr_in,
    input wire logic [`FPDC_DATA_BITS-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [`FPDC_DATA_BITS-1:0] rd_data_out,
    output logic init_done_out,
    output logic [7:0] grade_out,
    output logic ident_low_out,
    output logic [`FPDC_MUX_BITS-1:0] mux_addr_out,
    output logic extra_addr_bit_out,
    output logic row_strobe_n_a_out,
    output logic row_strobe_n_b_out,
    output logic col_strobe_n_a_out,
    output logic col_strobe_n_b_out,
    output logic write_en_n_a_out,
    output logic write_en_n_b_out,
    output logic out_en_n_a_out,
    output logic out_en_n_b_out,
    output logic detect_gate_n_out,
    input wire logic [7:0] detect_pattern_in,
    input wire logic ident_pin_a_in,
    input wire logic ident_pin_b_in,
    input wire logic [`FPDC_DATA_BITS-1:0] dq_in,
    output logic [`FPDC_DATA_BITS-1:0] dq_out,
    output logic dq_oe_out
);
    fpdc_timer_if tif ();
    fpdc_timer fpdc_timer_inst (.mclk_in(mclk_in), .rst_in(rst_in), .tmr(tif));

    fpdc_state_e state;
    logic [16:0] tload;
    logic tgo;
    logic [3:0] init_cnt;
    logic [31:0] ref_cnt;
    logic ref_pend;
    logic [16:0] ras_cnt;
    logic [`FPDC_ROW_BITS-1:0] open_row;
    logic cur_write;
    logic [`FPDC_COL_BITS-1:0] cur_col;
    logic [`FPDC_DATA_BITS-1:0] dq_s1, dq_s2;
    logic [7:0] pd_s1, pd_s2;
    logic [1:0] id_s1, id_s2;
    logic rd_take;
    logic rd_pipe;
    logic [`FPDC_ROW_BITS-1:0] req_row;

    assign req_row = req_addr_in[`FPDC_ADDR_BITS-1:`FPDC_COL_BITS];
    assign tif.load = tgo;
    assign tif.count = tload;

    // Pin inputs pass two flip-flops
    always_ff @(posedge mclk_in) begin
        dq_s1 <= dq_in;
        dq_s2 <= dq_s1;
        pd_s1 <= detect_pattern_in;
        pd_s2 <= pd_s1;
        id_s1 <= {ident_pin_b_in, ident_pin_a_in};
        id_s2 <= id_s1;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            detect_gate_n_out <= 1'b1;
            grade_out <= 8'h00;
            ident_low_out <= 1'b0;
        end else begin
            detect_gate_n_out <= 1'b0; // see R06
            grade_out <= pd_s2; // see R05
            ident_low_out <= (id_s2 == 2'h0); // see R07
        end
    end

    // Refresh interval timer
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ref_cnt <= 32'h00000000;
            ref_pend <= 1'b0;
        end else begin
            if (ref_cnt >= 32'(REF_INTERVAL_CYC - 1)) begin
                ref_cnt <= 32'h00000000;
            end else begin
                ref_cnt <= ref_cnt + 32'h00000001;
            end
            if (ref_cnt >= 32'(REF_INTERVAL_CYC - 1)) begin
                ref_pend <= 1'b1; // see R02
            end else if (state == FPDC_CBR && tgo) begin
                ref_pend <= 1'b0;
            end
        end
    end

    // Row-active time counter
    always_ff @(posedge mclk_in) begin
        if (rst_in || row_strobe_n_a_out) begin
            ras_cnt <= 17'h00000;
        end else if (ras_cnt != 17'h1FFFF) begin
            ras_cnt <= ras_cnt + 17'h00001;
        end
    end

    // Main sequencer
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= FPDC_WAIT_PWR;
            tgo <= 1'b1;
            tload <= 17'(PWRUP_CYC);
            init_cnt <= 4'h0;
            init_done_out <= 1'b0;
            req_ready_out <= 1'b0;
            row_strobe_n_a_out <= 1'b1;
            row_strobe_n_b_out <= 1'b1;
            col_strobe_n_a_out <= 1'b1;
            col_strobe_n_b_out <= 1'b1;
            write_en_n_a_out <= 1'b1;
            write_en_n_b_out <= 1'b1;
            out_en_n_a_out <= 1'b1;
            out_en_n_b_out <= 1'b1;
            mux_addr_out <= 11'h000;
            extra_addr_bit_out <= 1'b0;
            dq_out <= 72'h0;
            dq_oe_out <= 1'b0;
            open_row <= 12'h000;
            cur_write <= 1'b0;
            cur_col <= 10'h000;
            rd_take <= 1'b0;
        end else begin
            tgo <= 1'b0;
            req_ready_out <= 1'b0;
            rd_take <= 1'b0;
            unique case (state)
                FPDC_WAIT_PWR: begin
                    if (tif.done && !tgo) begin
                        state <= FPDC_CBR; // see R04
                        col_strobe_n_a_out <= 1'b0;
                        col_strobe_n_b_out <= 1'b0;
                        tgo <= 1'b1;
                        tload <= 17'(`FPDC_TCSR_CYC);
                    end
                end
                FPDC_CBR: begin
                    if (tif.done && !tgo) begin
                        if (row_strobe_n_a_out) begin
                            // Column strobes fall first; internal counter supplies the row
                            row_strobe_n_a_out <= 1'b0; // see R18
                            row_strobe_n_b_out <= 1'b0;
                            tgo <= 1'b1;
                            tload <= 17'(`FPDC_TRAS_CYC);
                        end else begin
                            row_strobe_n_a_out <= 1'b1;
                            row_strobe_n_b_out <= 1'b1;
                            col_strobe_n_a_out <= 1'b1;
                            col_strobe_n_b_out <= 1'b1;
                            state <= FPDC_PRECH;
                            tgo <= 1'b1;
                            tload <= 17'(`FPDC_TRP_CYC);
                            if (!init_done_out) begin
                                init_cnt <= init_cnt + 4'h1; // see R04
                            end
                        end
                    end
                end
                FPDC_PRECH: begin
                    if (tif.done && !tgo) begin
                        if (!init_done_out && init_cnt == 4'(`FPDC_INIT_REFRESHES)) begin
                            init_done_out <= 1'b1;
                        end
                        state <= FPDC_IDLE;
                    end
                end
                FPDC_IDLE: begin
                    {extra_addr_bit_out, mux_addr_out} <= req_row; // Set up ahead of the strobe, see R08
                    if (!init_done_out || ref_pend) begin
                        state <= FPDC_CBR; // see R02
                        col_strobe_n_a_out <= 1'b0;
                        col_strobe_n_b_out <= 1'b0;
                        tgo <= 1'b1;
                        tload <= 17'(`FPDC_TCSR_CYC);
                    end else if (req_valid_in && !req_ready_out && {extra_addr_bit_out, mux_addr_out} == req_row) begin
                        req_ready_out <= 1'b1;
                        open_row <= req_row;
                        cur_write <= req_write_in;
                        cur_col <= req_addr_in[`FPDC_COL_BITS-1:0];
                        dq_out <= req_wdata_in; // see R09 R01
                        row_strobe_n_a_out <= 1'b0; // see R10
                        row_strobe_n_b_out <= 1'b0;
                        state <= FPDC_ROW;
                        tgo <= 1'b1;
                        tload <= 17'(`FPDC_TRCD_CYC);
                    end
                end
                FPDC_ROW: begin
                    // Column phase; early write has enable low before the strobe
                    mux_addr_out <= {1'b0, cur_col};
                    extra_addr_bit_out <= 1'b0;
                    write_en_n_a_out <= !cur_write; // see R12 R16
                    write_en_n_b_out <= !cur_write;
                    out_en_n_a_out <= cur_write; // see R13
                    out_en_n_b_out <= cur_write;
                    dq_oe_out <= cur_write;
                    if (tif.done && !tgo) begin
                        col_strobe_n_a_out <= 1'b0; // see R11
                        col_strobe_n_b_out <= 1'b0;
                        state <= FPDC_COL;
                        tgo <= 1'b1;
                        tload <= 17'(`FPDC_TCAS_CYC);
                    end
                end
                FPDC_COL: begin
                    if (tif.done && !tgo) begin
                        rd_take <= !cur_write;
                        col_strobe_n_a_out <= 1'b1;
                        col_strobe_n_b_out <= 1'b1;
                        state <= FPDC_COL_PRE;
                        tgo <= 1'b1;
                        tload <= 17'(`FPDC_TCP_CYC); // see R15
                    end
                end
                FPDC_COL_PRE: begin
                    // Enables release only after the column strobe rose
                    write_en_n_a_out <= 1'b1; // see R17
                    write_en_n_b_out <= 1'b1;
                    out_en_n_a_out <= 1'b1;
                    out_en_n_b_out <= 1'b1;
                    dq_oe_out <= 1'b0;
                    if (tif.done && !tgo) begin
                        if (req_valid_in && !req_ready_out && !ref_pend && req_row == open_row &&
                            ras_cnt < 17'(PAGE_ROW_ACTIVE_MAX_CYC - 16) && ras_cnt < 17'(TRASN_CYC - 16)) begin
                            req_ready_out <= 1'b1;
                            cur_write <= req_write_in;
                            cur_col <= req_addr_in[`FPDC_COL_BITS-1:0];
                            dq_out <= req_wdata_in; // see R09
                            state <= FPDC_ROW;
                            tgo <= 1'b1; // Column set-up cycle before the strobe
                            tload <= 17'h00000;
                        end else if (ras_cnt >= 17'(`FPDC_TRAS_CYC)) begin
                            row_strobe_n_a_out <= 1'b1; // see R14
                            row_strobe_n_b_out <= 1'b1;
                            state <= FPDC_PRECH;
                            tgo <= 1'b1;
                            tload <= 17'(`FPDC_TRP_CYC);
                        end
                    end
                end
            endcase
        end
    end

    // Read data capture after synchroniser latency
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_pipe <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out <= 72'h0;
        end else begin
            rd_pipe <= rd_take;
            rd_valid_out <= rd_pipe;
            if (rd_pipe) begin
                rd_data_out <= dq_s2; // see R09
            end
        end
    end
endmodule // fpdc_ctrl
`default_nettype wire

// file: logic/fpdc_defines.svh
// Timing and layout constants for the fast-page DRAM module controller
`ifndef FPDC_DEFINES_SVH
`define FPDC_DEFINES_SVH
`define FPDC_CLK_NS 8
`define FPDC_ROW_BITS 12
`define FPDC_COL_BITS 10
`define FPDC_ADDR_BITS 22
`define FPDC_DATA_BITS 72
`define FPDC_MUX_BITS 11
`define FPDC_REF_ROWS 2048
`define FPDC_REF_PERIOD_MS 32
`define FPDC_REF_INTERVAL_CYC ((`FPDC_REF_PERIOD_MS * 1000000) / `FPDC_REF_ROWS / `FPDC_CLK_NS)
`define FPDC_PWRUP_US 100
`define FPDC_PWRUP_CYC ((`FPDC_PWRUP_US * 1000) / `FPDC_CLK_NS + 1)
`define FPDC_INIT_REFRESHES 8
`define FPDC_TRAS_NS 60
`define FPDC_TRAS_CYC ((`FPDC_TRAS_NS + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_TRP_NS 40
`define FPDC_TRP_CYC ((`FPDC_TRP_NS + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_TRCD_NS 20
`define FPDC_TRCD_CYC ((`FPDC_TRCD_NS + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_TCAS_NS 20
`define FPDC_TCAS_CYC ((`FPDC_TCAS_NS + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_TCP_NS 20
`define FPDC_TCP_CYC ((`FPDC_TCP_NS + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_TCSR_NS 5
`define FPDC_TCSR_CYC ((`FPDC_TCSR_NS + `FPDC_CLK_NS - 1) / `FPDC_CLK_NS)
`define FPDC_PAGE_ROW_ACTIVE_MAX_NS 125000
`define FPDC_PAGE_ROW_ACTIVE_MAX_CYC (`FPDC_PAGE_ROW_ACTIVE_MAX_NS / `FPDC_CLK_NS)
`define FPDC_TRASN_NS 10000
`define FPDC_TRASN_CYC (`FPDC_TRASN_NS / `FPDC_CLK_NS)
`define FPDC_PD_GRADE60 8'h6B
`endif

// file: logic/fpdc_pkg.sv
// Types for the fast-page DRAM module controller
package fpdc_pkg;
    typedef enum logic [7:0] {
        FPDC_WAIT_PWR = 8'h01,
        FPDC_INIT_REF = 8'h02,
        FPDC_IDLE = 8'h04,
        FPDC_ROW = 8'h08,
        FPDC_COL = 8'h10,
        FPDC_COL_PRE = 8'h20,
        FPDC_PRECH = 8'h40,
        FPDC_CBR = 8'h80
    } fpdc_state_e;
endpackage

// file: logic/fpdc_timer.sv
// Down counter that times strobe phases
`timescale 1ns/10ps
`default_nettype none
module fpdc_timer (
    input wire logic mclk_in,
    input wire logic rst_in,
    fpdc_timer_if.timer tmr
);
    logic [16:0] remain;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            remain <= 17'h00000;
        end else if (tmr.load) begin
            remain <= tmr.count;
        end else if (remain != 17'h00000) begin
            remain <= remain - 17'h00001;
        end
    end
    assign tmr.done = (remain == 17'h00000) && !tmr.load;
endmodule // fpdc_timer
`default_nettype wire

// file: logic/fpdc_timer_if.sv
// Load and done signals between the sequencer and its delay timer
`timescale 1ns/10ps
`default_nettype none
interface fpdc_timer_if;
    logic load;
    logic [16:0] count;
    logic done;
    modport owner (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// file: sim/fpdc_ctrl_bench.sv
// Self-checking bench for the fast-page DRAM controller
`timescale 1ns/10ps
`default_nettype none
module fpdc_ctrl_bench;
    localparam logic [71:0] D1 = 72'hC3F00D123456789ABC;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [21:0] req_addr_in = 22'h0;
    logic [71:0] req_wdata_in = 72'h0;
    logic req_ready_out, rd_valid_out, init_done_out, ident_low_out, extra_addr_bit_out, dq_oe_out;
    logic row_strobe_n_a_out, row_strobe_n_b_out, col_strobe_n_a_out, col_strobe_n_b_out, detect_gate_n_out;
    logic write_en_n_a_out, write_en_n_b_out, out_en_n_a_out, out_en_n_b_out;
    logic ident_pin_a_in, ident_pin_b_in;
    logic [71:0] rd_data_out, dq_out, mod_dq, dq_in, q;
    logic [10:0] mux_addr_out;
    logic [7:0] grade_out, detect_pattern_in;
    int refreshes;
    int num_errors = 0;
    int comparisons = 0;
    assign dq_in = dq_oe_out ? dq_out : mod_dq;
    fpdc_ctrl #(.PWRUP_CYC(20), .REF_INTERVAL_CYC(200), .PAGE_ROW_ACTIVE_MAX_CYC(400), .TRASN_CYC(100))
        fpdc_ctrl_inst (
        .mclk_in, .rst_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
        .req_ready_out, .rd_valid_out, .rd_data_out, .init_done_out, .grade_out, .ident_low_out,
        .mux_addr_out, .extra_addr_bit_out, .row_strobe_n_a_out, .row_strobe_n_b_out,
        .col_strobe_n_a_out, .col_strobe_n_b_out, .write_en_n_a_out, .write_en_n_b_out,
        .out_en_n_a_out, .out_en_n_b_out, .detect_gate_n_out, .detect_pattern_in,
        .ident_pin_a_in, .ident_pin_b_in, .dq_in, .dq_out, .dq_oe_out
    );
    fpdc_dram_model fpdc_dram_model_inst (
        .row_n_in({row_strobe_n_b_out, row_strobe_n_a_out}), .col_n_in({col_strobe_n_b_out, col_strobe_n_a_out}),
        .we_n_in({write_en_n_b_out, write_en_n_a_out}), .oe_n_in({out_en_n_b_out, out_en_n_a_out}),
        .gate_n_in(detect_gate_n_out), .addr_in({extra_addr_bit_out, mux_addr_out}), .dq_in(dq_in),
        .dq_out(mod_dq), .dq_en_out(), .pattern_out(detect_pattern_in),
        .ident_out({ident_pin_b_in, ident_pin_a_in}), .refresh_out(refreshes)
    );
    always #4 mclk_in = ~mclk_in;
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait: 0 ready, 1 read data
    task automatic wait_hi(input int which);
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while ((which == 0 ? req_ready_out : rd_valid_out) !== 1'b1 && n < 5000);
        if (n >= 5000)
            check(1'b0, 1'b1);
    endtask
    task automatic access(input logic wr, input logic [21:0] a, input logic [71:0] d);
        @(posedge mclk_in);
        req_valid_in <= 1'b1;
        req_write_in <= wr;
        req_addr_in <= a;
        req_wdata_in <= d;
        wait_hi(0);
        req_valid_in <= 1'b0;
        if (!wr) begin
            wait_hi(1);
            q = rd_data_out;
        end
    endtask
    task automatic t_reset;
        logic [9:0] s;
        #1;
        s = {row_strobe_n_a_out, row_strobe_n_b_out, col_strobe_n_a_out, col_strobe_n_b_out,
             write_en_n_a_out, write_en_n_b_out, out_en_n_a_out, out_en_n_b_out, dq_oe_out, init_done_out};
        check(s, 10'h3FC);
    endtask
    // Request raised during init must wait for it
    task automatic t_init;
        access(1'b1, 22'h0, 72'h0);
        check(init_done_out, 1'b1);
        check(refreshes >= 8, 1'b1);
    endtask
    task automatic t_presence;
        check(grade_out, 8'h6B);
        check(detect_gate_n_out, 1'b0);
        check(ident_low_out, 1'b1);
    endtask
    // Rows differing only in the extra address bit
    task automatic t_rw;
        access(1'b1, 22'h3FFFFF, D1);
        access(1'b1, 22'h1FFFFF, ~D1);
        access(1'b0, 22'h3FFFFF, 72'h0);
        check(q, D1);
        access(1'b0, 22'h1FFFFF, 72'h0);
        check(q, ~D1);
    endtask
    task automatic t_page;
        for (int k = 1; k < 4; k++)
            access(1'b1, 22'h155400 | 22'(k), {9{8'(8'h11 * k)}});
        for (int k = 1; k < 4; k++) begin
            access(1'b0, 22'h155400 | 22'(k), 72'h0);
            check(q, {9{8'(8'h11 * k)}});
        end
    endtask
    task automatic t_refresh;
        int r0;
        r0 = refreshes;
        repeat (1000) @(posedge mclk_in);
        check(refreshes - r0 >= 4, 1'b1);
        check(refreshes - r0 <= 6, 1'b1);
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_init();
        t_presence();
        t_rw();
        t_page();
        t_refresh();
        print_verdict();
    end
endmodule // fpdc_ctrl_bench
`default_nettype wire

// file: sim/fpdc_ctrl_props.sv
// Port assertions for the fast-page DRAM controller
`timescale 1ns/10ps
`default_nettype none
module fpdc_ctrl_props #(
    parameter int PWRUP_CYC = 20,
    parameter int PAGE_ROW_ACTIVE_MAX_CYC = 400
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic req_ready_out,
    input wire logic init_done_out,
    input wire logic row_strobe_n_a_out,
    input wire logic row_strobe_n_b_out,
    input wire logic col_strobe_n_a_out,
    input wire logic col_strobe_n_b_out,
    input wire logic write_en_n_a_out,
    input wire logic write_en_n_b_out,
    input wire logic out_en_n_a_out,
    input wire logic out_en_n_b_out,
    input wire logic dq_oe_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    int low_cyc;
    int up_cyc;
    // Cycles the row strobe has stayed low
    always_ff @(posedge mclk_in) begin
        if (rst_in || row_strobe_n_a_out)
            low_cyc <= 0;
        else
            low_cyc <= low_cyc + 1;
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in)
            up_cyc <= 0;
        else
            up_cyc <= up_cyc + 1;
    end
    property p_rows_pair; row_strobe_n_a_out == row_strobe_n_b_out; endproperty
    property p_cols_pair; col_strobe_n_a_out == col_strobe_n_b_out; endproperty
    property p_enables_pair; write_en_n_a_out == write_en_n_b_out && out_en_n_a_out == out_en_n_b_out; endproperty
    property p_row_limit; low_cyc < PAGE_ROW_ACTIVE_MAX_CYC; endproperty
    property p_page_gap; $fell(col_strobe_n_a_out) |=> (!$fell(col_strobe_n_a_out)) [*4]; endproperty
    property p_early_write; $fell(col_strobe_n_a_out) && !write_en_n_a_out |-> out_en_n_a_out && dq_oe_out; endproperty
    property p_dq_turn; !out_en_n_a_out |-> !dq_oe_out; endproperty
    property p_cbr_init; $fell(row_strobe_n_a_out) && !init_done_out |-> !col_strobe_n_a_out; endproperty
    property p_power_wait; $fell(col_strobe_n_a_out) && !init_done_out |-> up_cyc >= PWRUP_CYC; endproperty
    property p_ready_init; req_ready_out |-> init_done_out; endproperty
    a_rows_pair: assert property (p_rows_pair) else $error("row strobes differ");
    a_cols_pair: assert property (p_cols_pair) else $error("column strobes differ");
    a_enables_pair: assert property (p_enables_pair) else $error("enables differ");
    a_row_limit: assert property (p_row_limit) else $error("row strobe low too long");
    a_page_gap: assert property (p_page_gap) else $error("column accesses too close");
    a_early_write: assert property (p_early_write) else $error("early write bus state wrong");
    a_dq_turn: assert property (p_dq_turn) else $error("bus driven while module outputs");
    a_cbr_init: assert property (p_cbr_init) else $error("init refresh not column first");
    a_power_wait: assert property (p_power_wait) else $error("refresh before power wait");
    a_ready_init: assert property (p_ready_init) else $error("request taken before init");
    c_init: cover property ($rose(init_done_out));
    c_write: cover property ($fell(col_strobe_n_a_out) && !write_en_n_a_out);
    c_read: cover property (!out_en_n_a_out && !col_strobe_n_a_out);
endmodule // fpdc_ctrl_props
bind fpdc_ctrl fpdc_ctrl_props #(.PWRUP_CYC(PWRUP_CYC), .PAGE_ROW_ACTIVE_MAX_CYC(PAGE_ROW_ACTIVE_MAX_CYC))
    fpdc_ctrl_props_inst (
    .mclk_in, .rst_in, .req_ready_out, .init_done_out,
    .row_strobe_n_a_out, .row_strobe_n_b_out, .col_strobe_n_a_out, .col_strobe_n_b_out,
    .write_en_n_a_out, .write_en_n_b_out, .out_en_n_a_out, .out_en_n_b_out, .dq_oe_out
);
`default_nettype wire

// file: sim/fpdc_dram_model.sv
// Behavioural model of the 72-bit fast-page DRAM module
`timescale 1ns/10ps
`default_nettype none
module fpdc_dram_model (
    input wire logic [1:0] row_n_in,
    input wire logic [1:0] col_n_in,
    input wire logic [1:0] we_n_in,
    input wire logic [1:0] oe_n_in,
    input wire logic gate_n_in,
    input wire logic [11:0] addr_in,
    input wire logic [71:0] dq_in,
    output logic [71:0] dq_out,
    output logic dq_en_out,
    output logic [7:0] pattern_out,
    output logic [1:0] ident_out,
    output int refresh_out
);
    logic [35:0] lo [int];
    logic [35:0] hi [int];
    logic [11:0] row = 12'h0;
    logic [71:0] rdat = 72'h0;
    initial refresh_out = 0;
    assign ident_out = 2'b00;
    assign pattern_out = gate_n_in ? 8'h94 : 8'h6B;
    assign dq_en_out = row_n_in == 2'b00 && col_n_in == 2'b00 && oe_n_in == 2'b00 && we_n_in == 2'b11;
    // Released bus shows the inverse of the last word
    assign dq_out = dq_en_out ? rdat : ~rdat;
    always @(negedge row_n_in[0]) begin
        if (!col_n_in[0])
            refresh_out = refresh_out + 1;
        else
            row = addr_in;
    end
    always @(negedge col_n_in[0]) begin
        if (!row_n_in[0] && !we_n_in[0])
            lo[{row, addr_in[9:0]}] = dq_in[35:0];
        rdat[35:0] = lo.exists({row, addr_in[9:0]}) ? lo[{row, addr_in[9:0]}] : 36'h0;
    end
    always @(negedge col_n_in[1]) begin
        if (!row_n_in[1] && !we_n_in[1])
            hi[{row, addr_in[9:0]}] = dq_in[71:36];
        rdat[71:36] = hi.exists({row, addr_in[9:0]}) ? hi[{row, addr_in[9:0]}] : 36'h0;
    end
endmodule // fpdc_dram_model
`default_nettype wire
